// ### pkg/acs_pkg.sv
// Purpose: Shared constants and types for the ACL action staging block
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes:   Byte address of a register is four times its index
package acs_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 14;
  localparam logic [11:0] IDX_PRIO_ACTION = 12'h060A;
  localparam logic [11:0] IDX_REMARK_MAP  = 12'h060B;
  localparam logic [11:0] IDX_SPARE       = 12'h060C;
  localparam logic [11:0] IDX_FWD_MAP     = 12'h060D;
  localparam logic [11:0] IDX_RULESET_HI  = 12'h060E;
  localparam logic [11:0] IDX_RULESET_LO  = 12'h060F;
  localparam logic [11:0] IDX_SELECT_HI   = 12'h0610;
  localparam logic [11:0] IDX_SELECT_LO   = 12'h0611;
  localparam logic [11:0] IDX_CONTROL     = 12'h0612;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned NUM_ACT_BYTES  = 6;
  localparam int unsigned REMARK_HI_MSB  = 1;
  localparam int unsigned REMARK_LO_BIT  = 7;
  localparam int unsigned FWD_MAP_MSB    = 6;
  localparam int unsigned CTL_WDONE_BIT  = 6;
  localparam int unsigned CTL_RDONE_BIT  = 5;
  localparam int unsigned CTL_DIR_BIT    = 4;
  localparam int unsigned CTL_INDEX_MSB  = 3;
  localparam logic [7:0]  BYTE_RESET     = 8'h00;
  localparam logic [7:0]  CTL_MASK       = 8'h1F;
  localparam int unsigned ACCESS_CYCLES  = 4;

  // ----------------------------------------------------------------
  // Access sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b01,
    ACS_BUSY = 2'b10
  } acs_state_t;

endpackage

// ### logic/acs_staging_byte.sv
// Purpose: One staging byte, written by software or loaded from the table
// Assumes: Software write and table load never coincide
// Notes:   Table load has priority should both ever occur
`timescale 1ns/1ps
module acs_staging_byte (
  input  wire logic       core_clk_in,  // Core clock
  input  wire logic       reset_in,     // Sync reset, high
  input  wire logic       sw_we_in,     // Software write strobe
  input  wire logic [7:0] sw_data_in,   // Software write data
  input  wire logic       load_in,      // Table read load strobe
  input  wire logic [7:0] load_data_in, // Table content
  output logic      [7:0] q_out         // Held byte
);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      q_out <= acs_pkg::BYTE_RESET;
    end else if (load_in) begin
      q_out <= load_data_in;
    end else if (sw_we_in) begin
      q_out <= sw_data_in;
    end
  end

endmodule // acs_staging_byte

// ### logic/acs_access_timer.sv
// Purpose: Counts out the table access time and pulses on completion
// Assumes: start_in only while not running
// Notes:   done_out is a one-cycle pulse
`timescale 1ns/1ps
module acs_access_timer #(
  parameter int unsigned CYCLES = acs_pkg::ACCESS_CYCLES
) (
  input  wire logic core_clk_in, // Core clock
  input  wire logic reset_in,    // Sync reset, high
  input  wire logic start_in,    // Begin an access
  output logic      done_out     // Access finished pulse
);

  logic [7:0] count_reg;
  logic       run_reg;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      count_reg <= 8'h00;
      run_reg   <= 1'b0;
      done_out  <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in) begin
        count_reg <= 8'(CYCLES - 1);
        run_reg   <= 1'b1;
      end else if (run_reg) begin
        if (count_reg == 8'h00) begin
          run_reg  <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count_reg <= count_reg - 8'h01;
        end
      end
    end
  end

endmodule // acs_access_timer

// ### logic/acs_acl_entry_staging_access.sv
// Purpose: Staging registers and sequencer for one ACL entry's action bytes
// Assumes: Classic Wishbone slave, 32-bit data, byte lane 0 carries data
// Notes:   Key-match bytes 0..9 live elsewhere; their enables are ignored
//
// Function
// - Remark priority bits 2:1 sit in bits 1:0 of the priority action byte.
// - Remark priority bit 0 sits in bit 7 of the second action byte.
// - Forward map bit 0 is port 1, bit 1 port 2, upward to bit 6.
// - Forward map one allows forwarding to that port, zero blocks it.
// - High select bit 0 picks byte 7, down to bit 7 picking byte 0.
// - Low select bit 0 picks byte F, down to bit 7 picking byte 8.
// - Only enabled staging bytes take part in a table read or write.
// - Writing the low select register starts the access; software sets up first.
// - Write status reads zero during a table write, one after it and reset.
// - Read status reads zero during a table read; software polls for one.
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module acs_acl_entry_staging_access #(
  parameter int unsigned ENTRIES       = 16,
  parameter int unsigned ACCESS_CYCLES = acs_pkg::ACCESS_CYCLES
) (
  input  wire logic                       core_clk_in,            // Core clock, 40 MHz
  input  wire logic                       reset_in,               // Sync reset, high
  input  wire logic                       wb_cyc_in,              // Bus cycle
  input  wire logic                       wb_stb_in,              // Bus strobe
  input  wire logic                       wb_we_in,               // Write enable
  input  wire logic [acs_pkg::ADDR_W-1:0] wb_adr_in,              // Byte address
  input  wire logic [3:0]                 wb_sel_in,              // Byte lane selects
  input  wire logic [31:0]                wb_dat_in,              // Write data
  output logic      [31:0]                wb_dat_out,             // Read data
  output logic                            wb_ack_out,             // Acknowledge
  input  wire logic [3:0]                 lookup_index_in,        // Entry for lookup
  output logic      [6:0]                 lookup_forward_map_out, // Allowed egress ports
  output logic      [2:0]                 lookup_remark_out,      // Remark priority value
  output logic      [15:0]                lookup_ruleset_out,     // Ruleset of entry
  output logic                            busy_out                // Table access running
);

  localparam int unsigned NB = acs_pkg::NUM_ACT_BYTES;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        ack_reg;
  wire  [11:0] word_idx  = wb_adr_in[acs_pkg::ADDR_W-1:2];
  wire         req       = wb_cyc_in & wb_stb_in & ~ack_reg;
  // Write lands on the ack edge, the one edge where the master samples ack
  wire         wr_take   = wb_cyc_in & wb_stb_in & ack_reg & wb_we_in & wb_sel_in[0];
  wire  [7:0]  wr_byte   = wb_dat_in[7:0];

  acs_pkg::acs_state_t state_reg;
  acs_pkg::acs_state_t state_next;
  wire idle = (state_reg == acs_pkg::ACS_IDLE);

  wire hit_sel_hi = (word_idx == acs_pkg::IDX_SELECT_HI);
  wire hit_sel_lo = (word_idx == acs_pkg::IDX_SELECT_LO);
  wire hit_ctl    = (word_idx == acs_pkg::IDX_CONTROL);
  wire hit_prio   = (word_idx == acs_pkg::IDX_PRIO_ACTION);
  wire hit_remark = (word_idx == acs_pkg::IDX_REMARK_MAP);
  wire hit_spare  = (word_idx == acs_pkg::IDX_SPARE);
  wire hit_fwd    = (word_idx == acs_pkg::IDX_FWD_MAP);
  wire hit_rs_hi  = (word_idx == acs_pkg::IDX_RULESET_HI);
  wire hit_rs_lo  = (word_idx == acs_pkg::IDX_RULESET_LO);

  // ----------------------------------------------------------------
  // Control and select registers
  // ----------------------------------------------------------------
  logic [7:0] sel_hi_reg;
  logic [7:0] sel_lo_reg;
  logic       dir_write_reg;
  logic [3:0] index_reg;
  logic       wdone_reg;
  logic       rdone_reg;

  wire go = wr_take & hit_sel_lo & idle;
  wire access_done;

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      sel_hi_reg    <= acs_pkg::BYTE_RESET;
      sel_lo_reg    <= acs_pkg::BYTE_RESET;
      dir_write_reg <= 1'b0;
      index_reg     <= 4'h0;
    end else if (wr_take & idle) begin
      if (hit_sel_hi) begin
        sel_hi_reg <= wr_byte;
      end
      if (hit_sel_lo) begin
        sel_lo_reg <= wr_byte;
      end
      if (hit_ctl) begin
        dir_write_reg <= wr_byte[acs_pkg::CTL_DIR_BIT];
        index_reg     <= wr_byte[acs_pkg::CTL_INDEX_MSB:0];
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      wdone_reg <= 1'b1;
      rdone_reg <= 1'b1;
    end else if (access_done) begin
      wdone_reg <= 1'b1;
      rdone_reg <= 1'b1;
    end else if (go) begin
      wdone_reg <= ~dir_write_reg;
      rdone_reg <= dir_write_reg;
    end
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  always_comb begin
    case (state_reg)
      acs_pkg::ACS_IDLE: state_next = go ? acs_pkg::ACS_BUSY : acs_pkg::ACS_IDLE;
      acs_pkg::ACS_BUSY: state_next = access_done ? acs_pkg::ACS_IDLE : acs_pkg::ACS_BUSY;
      default:           state_next = acs_pkg::ACS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_reg <= acs_pkg::ACS_IDLE;
      busy_out  <= 1'b0;
    end else begin
      state_reg <= state_next;
      busy_out  <= (state_next == acs_pkg::ACS_BUSY);
    end
  end

  acs_access_timer #(
    .CYCLES (ACCESS_CYCLES)
  ) u_timer (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .start_in    (go),
    .done_out    (access_done)
  );

  // ----------------------------------------------------------------
  // Staging bytes A..F and entry table
  // ----------------------------------------------------------------
  logic [47:0] table_reg [ENTRIES];
  wire  [47:0] row_sel  = table_reg[index_reg];
  wire  [47:0] row_merge;
  wire  [7:0]  stg_q [NB];
  wire  [15:0] byte_en = {sel_hi_reg, sel_lo_reg};
  wire         load_rd = access_done & ~dir_write_reg;
  wire         store_wr = access_done & dir_write_reg;

  genvar gi;
  generate
    for (gi = 0; gi < NB; gi++) begin : g_lane
      // byte k enabled by bit 15-k
      wire lane_en = byte_en[5 - gi];
      wire lane_we = wr_take & idle & (word_idx == 12'(acs_pkg::IDX_PRIO_ACTION + gi));
      assign row_merge[47-8*gi -: 8] = lane_en ? stg_q[gi] : row_sel[47-8*gi -: 8];

      acs_staging_byte u_byte (
        .core_clk_in  (core_clk_in),
        .reset_in     (reset_in),
        .sw_we_in     (lane_we),
        .sw_data_in   (wr_byte),
        .load_in      (load_rd & lane_en),
        .load_data_in (row_sel[47-8*gi -: 8]),
        .q_out        (stg_q[gi])
      );
    end
  endgenerate

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      for (int e = 0; e < ENTRIES; e++) begin
        table_reg[e] <= 48'h0000_0000_0000;
      end
    end else if (store_wr) begin
      table_reg[index_reg] <= row_merge;
    end
  end

  // ----------------------------------------------------------------
  // Lookup port
  // ----------------------------------------------------------------
  wire [47:0] row_look = table_reg[lookup_index_in];

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      lookup_forward_map_out <= 7'h00;
      lookup_remark_out      <= 3'h0;
      lookup_ruleset_out     <= 16'h0000;
    end else begin
      lookup_forward_map_out <= row_look[16 + acs_pkg::FWD_MAP_MSB : 16];
      lookup_remark_out      <= {row_look[40 + acs_pkg::REMARK_HI_MSB : 40],
                                 row_look[32 + acs_pkg::REMARK_LO_BIT]};
      // ruleset in bytes E and F
      lookup_ruleset_out     <= row_look[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------------------------------
  wire [7:0] ctl_byte = {1'b0, wdone_reg, rdone_reg, dir_write_reg, index_reg};
  wire [7:0] rd_byte =
    hit_prio   ? stg_q[0] :
    hit_remark ? stg_q[1] :
    hit_spare  ? stg_q[2] :
    hit_fwd    ? stg_q[3] :
    hit_rs_hi  ? stg_q[4] :
    hit_rs_lo  ? stg_q[5] :
    hit_sel_hi ? sel_hi_reg :
    hit_sel_lo ? sel_lo_reg :
    hit_ctl    ? ctl_byte : 8'h00;

  // Single-cycle answer; ack never held into a second cycle
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      ack_reg    <= 1'b0;
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      ack_reg    <= req;
      wb_ack_out <= req;
      if (req & ~wb_we_in) begin
        wb_dat_out <= {24'h00_0000, rd_byte};
      end
    end
  end

endmodule // acs_acl_entry_staging_access

// ### sim/acs_acl_entry_staging_access_assertions.sv
// Purpose: Bus and sequencer checks for the ACL staging block
// Assumes: Byte address is four times the register index
// Notes:   Sees only the top module ports
`timescale 1ns/1ps
module acs_acl_entry_staging_access_assertions #(
  parameter int unsigned ACCESS_CYCLES = acs_pkg::ACCESS_CYCLES
) (
  input wire logic                       core_clk_in, // Core clock
  input wire logic                       reset_in,    // Sync reset, high
  input wire logic                       wb_cyc_in,   // Bus cycle
  input wire logic                       wb_stb_in,   // Bus strobe
  input wire logic                       wb_we_in,    // Write enable
  input wire logic [acs_pkg::ADDR_W-1:0] wb_adr_in,   // Byte address
  input wire logic [3:0]                 wb_sel_in,   // Byte lane selects
  input wire logic [31:0]                wb_dat_out,  // Read data
  input wire logic                       wb_ack_out,  // Acknowledge
  input wire logic                       busy_out     // Access running
);
  // Slack of one cycle on the access length
  localparam int BUSY_MAX = ACCESS_CYCLES + 2;
  wire logic        take = wb_cyc_in && wb_stb_in && !wb_ack_out;
  wire logic [11:0] idx  = wb_adr_in[13:2];
  // Writes land on the ack edge, so the start is seen there
  wire logic        go   = wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in &&
                           wb_sel_in[0] && idx == acs_pkg::IDX_SELECT_LO;
  wire logic        rctl = take && !wb_we_in && idx == acs_pkg::IDX_CONTROL;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  ack_delay_a: assert property (take |=> wb_ack_out) else $error("ack late");
  ack_single_a: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held");
  ack_cause_a: assert property (wb_ack_out |-> $past(take)) else $error("stray ack");
  busy_start_a: assert property (go && !busy_out |=> busy_out)
    else $error("access not started");
  busy_end_a: assert property ($rose(busy_out) |-> ##[1:BUSY_MAX] !busy_out)
    else $error("access too long");
  upper_zero_a: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h00_0000)
    else $error("upper data set");
  unmapped_zero_a: assert property (take && !wb_we_in && idx > acs_pkg::IDX_CONTROL
    |=> wb_dat_out == 32'h0000_0000) else $error("unmapped read nonzero");
  status_busy_a: assert property (rctl ##1 busy_out |-> wb_dat_out[6:5] != 2'b11)
    else $error("done flags while busy");

  go_c: cover property (go);
  poll_c: cover property (rctl ##1 busy_out);
  done_c: cover property ($fell(busy_out));
endmodule // acs_acl_entry_staging_access_assertions

bind acs_acl_entry_staging_access acs_acl_entry_staging_access_assertions #(
  .ACCESS_CYCLES(ACCESS_CYCLES)) chk (.core_clk_in, .reset_in, .wb_cyc_in, .wb_stb_in,
  .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_out, .wb_ack_out, .busy_out);

// ### sim/acs_acl_entry_staging_access_tb.sv
// Purpose: Self-checking bench for the ACL staging block
// Assumes: Byte address is four times the register index
// Notes:   Each scenario drives the bus and judges the replies
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module acs_acl_entry_staging_access_tb;
  logic        core_clk_in     = 1'b0;
  logic        reset_in        = 1'b1;
  logic        wb_cyc_in       = 1'b0;
  logic        wb_stb_in       = 1'b0;
  logic        wb_we_in        = 1'b0;
  logic [13:0] wb_adr_in       = 14'h0000;
  logic [3:0]  wb_sel_in       = 4'h0;
  logic [31:0] wb_dat_in       = 32'h0000_0000;
  logic [3:0]  lookup_index_in = 4'h0;
  logic [31:0] wb_dat_out;
  logic        wb_ack_out;
  logic [6:0]  lookup_forward_map_out;
  logic [2:0]  lookup_remark_out;
  logic [15:0] lookup_ruleset_out;
  logic        busy_out;
  logic [7:0]  rd;
  int          failures        = 0;
  int          checks_done     = 0;

  acs_acl_entry_staging_access #(.ENTRIES(16), .ACCESS_CYCLES(4)) dut (.core_clk_in,
    .reset_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in,
    .wb_dat_out, .wb_ack_out, .lookup_index_in, .lookup_forward_map_out,
    .lookup_remark_out, .lookup_ruleset_out, .busy_out);

  initial forever #12.5 core_clk_in = ~core_clk_in;

  task automatic tally_and_finish();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Holds the request until ack is seen, then releases
  task automatic wb(input logic we, input logic [11:0] idx, input logic [7:0] d);
    int n;
    @(posedge core_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in  <= we;
    wb_adr_in <= {idx, 2'b00};
    wb_sel_in <= 4'h1;
    wb_dat_in <= {24'h00_0000, d};
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    if (wb_ack_out !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
    // Data taken and request released at the edge that saw ack
    rd = wb_dat_out[7:0];
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask

  task automatic rc(input logic [11:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00);
    `CHK(rd, e)
  endtask

  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      wb(1'b0, acs_pkg::IDX_CONTROL, 8'h00);
      n++;
    end while (rd[b] !== 1'b1 && n < 50);
    `CHK(rd[b], 1'b1)
    if (rd[b] !== 1'b1) tally_and_finish();
  endtask

  task automatic look(input logic [6:0] m, input logic [2:0] r, input logic [15:0] s);
    @(posedge core_clk_in);
    lookup_index_in <= 4'h3;
    repeat (3) @(posedge core_clk_in);
    @(negedge core_clk_in);
    `CHK(lookup_forward_map_out, m)
    `CHK(lookup_remark_out, r)
    `CHK(lookup_ruleset_out, s)
  endtask

  task automatic s_reset();
    rc(acs_pkg::IDX_RULESET_HI, 8'h00);
    rc(acs_pkg::IDX_RULESET_LO, 8'h00);
    rc(acs_pkg::IDX_CONTROL, 8'h60);
    rc(12'h0640, 8'h00);
  endtask

  // Neighbouring bits set so a field slip shows
  task automatic s_write();
    wb(1'b1, acs_pkg::IDX_PRIO_ACTION, 8'hFE);
    wb(1'b1, acs_pkg::IDX_REMARK_MAP, 8'hFF);
    wb(1'b1, acs_pkg::IDX_FWD_MAP, 8'hC5);
    wb(1'b1, acs_pkg::IDX_RULESET_HI, 8'h12);
    wb(1'b1, acs_pkg::IDX_RULESET_LO, 8'h34);
    wb(1'b1, acs_pkg::IDX_CONTROL, 8'h13);
    wb(1'b1, acs_pkg::IDX_SELECT_HI, 8'hFF);
    wb(1'b1, acs_pkg::IDX_SELECT_LO, 8'h3F);
    wb(1'b0, acs_pkg::IDX_CONTROL, 8'h00);
    `CHK(rd[6], 1'b0)
    `CHK(busy_out, 1'b1)
    poll(6);
    `CHK(busy_out, 1'b0)
    look(7'h45, 3'b101, 16'h1234);
  endtask

  task automatic s_partial();
    wb(1'b1, acs_pkg::IDX_RULESET_HI, 8'hAA);
    wb(1'b1, acs_pkg::IDX_RULESET_LO, 8'h55);
    wb(1'b1, acs_pkg::IDX_SELECT_LO, 8'h01);
    poll(6);
    look(7'h45, 3'b101, 16'h1255);
  endtask

  task automatic s_read();
    wb(1'b1, acs_pkg::IDX_RULESET_HI, 8'h00);
    wb(1'b1, acs_pkg::IDX_RULESET_LO, 8'h00);
    wb(1'b1, acs_pkg::IDX_FWD_MAP, 8'h00);
    wb(1'b1, acs_pkg::IDX_CONTROL, 8'h03);
    wb(1'b1, acs_pkg::IDX_SELECT_LO, 8'h02);
    wb(1'b0, acs_pkg::IDX_CONTROL, 8'h00);
    `CHK(rd[5], 1'b0)
    poll(5);
    rc(acs_pkg::IDX_RULESET_HI, 8'h12);
    rc(acs_pkg::IDX_RULESET_LO, 8'h00);
    rc(acs_pkg::IDX_FWD_MAP, 8'h00);
  endtask

  initial begin
    repeat (12) @(posedge core_clk_in);
    reset_in <= 1'b0;
    s_reset();
    s_write();
    s_partial();
    s_read();
    tally_and_finish();
  end
endmodule // acs_acl_entry_staging_access_tb
